// File: logic/rfrm_register_map.sv
// Host-visible register bank of the reader front end
// Function
// R1 - Enable low or reset loads 0x01
// R2 - B7 standby; active ready after wake time
// R3 - B6 selects direct or framed operation
// R4 - Host sets direct variant before direct bit
// R5 - B5 switches transmitter and receivers on
// R6 - B4 selects half or full power
// R7 - B3 selects auxiliary or main input
// R8 - B1 forces receiver and oscillator on
// R9 - B1 clear: receiver follows RF enable
// R10 - B0 selects 5 V or 3 V supply
// R11 - Enable low or reset loads protocol 0x02
// R12 - 0x0D read/write, 0x0E read-only
// R13 - 0x0F signal level is read-only
// R14 - 0x09 modulator/clock control read/write
// R15 - 0x0B regulator/IO control read/write
// R16 - First word: command, read, continuous, address
// R17 - Protocol write reloads option registers 0x02-0x0B
// R18 - Clock divider bits survive protocol preset
// R19 - Read-only/unlisted writes ignored, unlisted read zero
`timescale 1ns/1ps
`default_nettype none
module rfrm_register_map
    import rfrm_pkg::*;
#(
    parameter int WAKE_COUNT = WAKE_CYCLES
) (
    // Clock and reset
    input  wire logic        core_clk_in,
    input  wire logic        rst_n_in,
    input  wire logic        chip_enable_in,
    // Host port
    input  wire logic        frame_active_in,
    input  wire logic        byte_valid_in,
    input  wire logic [7:0]  byte_in,
    output logic [7:0]       rd_data_out,
    output logic             rd_valid_out,
    output logic             cmd_valid_out,
    output logic [4:0]       cmd_code_out,
    // FIFO side
    input  wire logic [7:0]  fifo_rd_data_in,
    output logic             fifo_rd_out,
    output logic             fifo_wr_out,
    output logic [7:0]       fifo_wr_data_out,
    // Status sources
    input  wire logic [7:0]  irq_status_in,
    input  wire logic [7:0]  collision_pos_in,
    input  wire logic [7:0]  signal_level_in,
    input  wire logic [7:0]  fifo_status_in,
    // Front end controls
    output logic             standby_out,
    output logic             active_ready_out,
    output logic             direct_mode_out,
    output logic             rf_output_enable_out,
    output logic             receiver_enable_out,
    output logic             tx_osc_enable_out,
    output logic             half_power_select_out,
    output logic             aux_input_select_out,
    output logic             supply_range_select_out,
    output logic [7:0]       protocol_control_out,
    output logic [7:0]       modulator_clock_out_control_out
);

    function automatic logic rfrm_is_rw(input logic [4:0] a);
        unique case (a)
            ADDR_CSC, ADDR_PROTO, ADDR_TYPEB_TX, ADDR_TYPEA_HBR,
            ADDR_TX_PULSE, ADDR_RX_NORESP, ADDR_RX_WAIT,
            ADDR_MOD_CLK, ADDR_RX_SPEC, ADDR_REG_IO, ADDR_COLL_MASK,
            ADDR_TEST_ONE, ADDR_TEST_TWO, ADDR_TXLEN_HI,
            ADDR_TXLEN_LO: rfrm_is_rw = 1'b1;
            default:       rfrm_is_rw = 1'b0;
        endcase
    endfunction

    function automatic logic [7:0] rfrm_rst_val(input logic [4:0] a);
        if (a == ADDR_CSC) begin
            rfrm_rst_val = CSC_RST;
        end else if (a == ADDR_PROTO) begin
            rfrm_rst_val = PROTO_RST;
        end else begin
            rfrm_rst_val = OPT_RST;
        end
    endfunction

    logic [1:0]  rst_sync_ff;
    logic        rst_n;
    rfrm_state_t state_ff;
    logic [4:0]  addr_ff;
    logic        cont_ff;
    logic [7:0]  regs_ff [32];
    logic [7:0]  rd_data_ff;
    logic        rd_valid_ff;
    logic        cmd_valid_ff;
    logic [4:0]  cmd_code_ff;
    logic        fifo_wr_ff;
    logic [7:0]  fifo_wr_data_ff;
    logic        take;
    logic        cmd_take;
    logic        soft_init;
    logic        wr_en;
    logic        rd_en;
    logic        preset;
    logic [7:0]  rd_mux;
    rfrm_csc_t   csc;

    // Asynchronous assert, synchronous release
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rst_sync_ff <= 2'b00;
        end else begin
            rst_sync_ff <= {rst_sync_ff[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_ff[1];

    assign take      = frame_active_in && byte_valid_in;
    assign cmd_take  = take && (state_ff == ST_ADDR)
                       && byte_in[WORD_CMD_BIT]; // R16
    assign soft_init = cmd_take && (byte_in[4:0] == CMD_SOFT_INIT);
    assign wr_en     = take && (state_ff == ST_WRITE);
    assign rd_en     = take && (state_ff == ST_READ);
    assign preset    = wr_en && (addr_ff == ADDR_PROTO); // R17

    // Access sequencing; frame end always returns to the address word
    always_ff @(posedge core_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= ST_ADDR;
        end else if (!frame_active_in) begin
            state_ff <= ST_ADDR;
        end else if (byte_valid_in) begin
            unique case (state_ff)
                ST_ADDR: begin
                    if (byte_in[WORD_CMD_BIT]) begin // R16
                        state_ff <= ST_HOLD;
                    end else if (byte_in[WORD_RD_BIT]) begin
                        state_ff <= ST_READ;
                    end else begin
                        state_ff <= ST_WRITE;
                    end
                end
                ST_WRITE, ST_READ: begin
                    if (!cont_ff) begin
                        state_ff <= ST_HOLD;
                    end
                end
                ST_HOLD: begin
                    state_ff <= ST_HOLD;
                end
            endcase
        end
    end

    // Address pointer; continuous mode steps it per data byte
    always_ff @(posedge core_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            addr_ff <= 5'h00;
            cont_ff <= 1'b0;
        end else if (take && state_ff == ST_ADDR) begin
            addr_ff <= byte_in[4:0]; // R16
            cont_ff <= byte_in[WORD_CONT_BIT];
        end else if ((wr_en || rd_en) && cont_ff) begin
            addr_ff <= addr_ff + 5'h01;
        end
    end

    // Register storage; only writable addresses hold state
    for (genvar i = 0; i < 32; i++) begin : g_reg
        localparam logic [4:0] A = 5'(i);
        if (rfrm_is_rw(A)) begin : g_rw
            always_ff @(posedge core_clk_in or negedge rst_n) begin
                if (!rst_n) begin
                    regs_ff[i] <= rfrm_rst_val(A);
                end else if (!chip_enable_in || soft_init) begin
                    regs_ff[i] <= rfrm_rst_val(A); // R1 R11
                end else if (wr_en && addr_ff == A) begin
                    regs_ff[i] <= byte_in; // R12 R14 R15
                end else if (preset && A >= ADDR_TYPEB_TX
                             && A <= ADDR_REG_IO) begin
                    if (A == ADDR_MOD_CLK) begin
                        regs_ff[i] <= (regs_ff[i] & MOD_CLKDIV_MASK)
                                      | (OPT_RST & ~MOD_CLKDIV_MASK); // R18
                    end else begin
                        regs_ff[i] <= OPT_RST; // R17
                    end
                end
            end
        end else begin : g_none
            assign regs_ff[i] = 8'h00; // R19
        end
    end

    // Read-only views come straight from their sources
    always_comb begin
        unique case (addr_ff)
            ADDR_IRQ_STAT:  rd_mux = irq_status_in;
            ADDR_COLL_POS:  rd_mux = collision_pos_in; // R12
            ADDR_SIG_LEVEL: rd_mux = signal_level_in; // R13
            ADDR_FIFO_STAT: rd_mux = fifo_status_in;
            ADDR_FIFO_DATA: rd_mux = fifo_rd_data_in;
            default:        rd_mux = regs_ff[addr_ff]; // R19
        endcase
    end

    always_ff @(posedge core_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            rd_data_ff  <= 8'h00;
            rd_valid_ff <= 1'b0;
        end else begin
            rd_valid_ff <= rd_en;
            if (rd_en) begin
                rd_data_ff <= rd_mux;
            end
        end
    end

    always_ff @(posedge core_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            cmd_valid_ff <= 1'b0;
            cmd_code_ff  <= 5'h00;
        end else begin
            cmd_valid_ff <= cmd_take;
            if (cmd_take) begin
                cmd_code_ff <= byte_in[4:0];
            end
        end
    end

    // FIFO writes are registered for one cycle, then passed on; no register slot holds them
    always_ff @(posedge core_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            fifo_wr_ff      <= 1'b0;
            fifo_wr_data_ff <= 8'h00;
        end else begin
            fifo_wr_ff <= wr_en && (addr_ff == ADDR_FIFO_DATA);
            if (wr_en && addr_ff == ADDR_FIFO_DATA) begin
                fifo_wr_data_ff <= byte_in;
            end
        end
    end

    assign fifo_rd_out      = rd_en && (addr_ff == ADDR_FIFO_DATA);
    assign rd_data_out      = rd_data_ff;
    assign rd_valid_out     = rd_valid_ff;
    assign cmd_valid_out    = cmd_valid_ff;
    assign cmd_code_out     = cmd_code_ff;
    assign fifo_wr_out      = fifo_wr_ff;
    assign fifo_wr_data_out = fifo_wr_data_ff;

    // Direct bit is taken as written; the host orders its writes
    assign csc                     = rfrm_csc_t'(regs_ff[ADDR_CSC]);
    assign standby_out             = csc.standby; // R2
    assign direct_mode_out         = csc.direct_mode; // R3 R4
    assign rf_output_enable_out    = csc.rf_output_enable; // R5
    assign half_power_select_out   = csc.half_power_select; // R6
    assign aux_input_select_out    = csc.aux_input_select; // R7
    assign supply_range_select_out = csc.supply_range_select; // R10
    assign receiver_enable_out     = csc.receiver_force
                                     || csc.rf_output_enable; // R8 R9
    assign tx_osc_enable_out       = csc.receiver_force
                                     || csc.rf_output_enable; // R8
    assign protocol_control_out    = regs_ff[ADDR_PROTO];
    assign modulator_clock_out_control_out = regs_ff[ADDR_MOD_CLK];

    rfrm_wake_timer #(
        .WAKE_COUNT (WAKE_COUNT)
    ) u_wake (
        .core_clk_in (core_clk_in),
        .rst_n_in    (rst_n),
        .standby_in  (csc.standby),
        .ready_out   (active_ready_out)
    ); // R2

    sequence s_csc_write;
        wr_en && addr_ff == ADDR_CSC && chip_enable_in && !soft_init;
    endsequence

    property p_enable_low;
        @(posedge core_clk_in) disable iff (!rst_n)
        !chip_enable_in |=> regs_ff[ADDR_CSC] == 8'h01
                            && regs_ff[ADDR_PROTO] == 8'h02;
    endproperty
    a_enable_low: assert property (p_enable_low) // R1
        else $error("enable low did not load defaults");

    property p_standby_bit;
        @(posedge core_clk_in) disable iff (!rst_n)
        s_csc_write |=> standby_out == $past(byte_in[7]);
    endproperty
    a_standby_bit: assert property (p_standby_bit) // R2
        else $error("standby does not follow B7");

    property p_direct_bit;
        @(posedge core_clk_in) disable iff (!rst_n)
        s_csc_write |=> direct_mode_out == $past(byte_in[6]);
    endproperty
    a_direct_bit: assert property (p_direct_bit) // R3
        else $error("direct mode does not follow B6");

    property p_rf_output_enable;
        @(posedge core_clk_in) disable iff (!rst_n)
        s_csc_write ##1 !$past(byte_in[1]) |->
            receiver_enable_out == $past(byte_in[5]);
    endproperty
    a_rf_output_enable: assert property (p_rf_output_enable) // R9
        else $error("receiver does not follow RF enable");

    property p_force_rx;
        @(posedge core_clk_in) disable iff (!rst_n)
        s_csc_write ##0 byte_in[1] |=> receiver_enable_out
                                        && tx_osc_enable_out;
    endproperty
    a_force_rx: assert property (p_force_rx) // R8
        else $error("forced receiver not on");

    property p_preset;
        @(posedge core_clk_in) disable iff (!rst_n)
        preset && chip_enable_in && !soft_init |=>
            regs_ff[ADDR_TYPEB_TX] == OPT_RST
            && (regs_ff[ADDR_MOD_CLK] & MOD_CLKDIV_MASK)
               == ($past(regs_ff[ADDR_MOD_CLK]) & MOD_CLKDIV_MASK);
    endproperty
    a_preset: assert property (p_preset) // R17
        else $error("protocol preset wrong");

    property p_unlisted_read;
        @(posedge core_clk_in) disable iff (!rst_n)
        rd_en && addr_ff == 5'h05 |=> rd_valid_out && rd_data_out == 8'h00;
    endproperty
    a_unlisted_read: assert property (p_unlisted_read) // R19
        else $error("unlisted read not zero");

    property p_command;
        @(posedge core_clk_in) disable iff (!rst_n)
        cmd_take |=> cmd_valid_out ##1 !cmd_valid_out;
    endproperty
    a_command: assert property (p_command) // R16
        else $error("command strobe wrong");

endmodule
`default_nettype wire

// File: logic/rfrm_pkg.sv
// Shared constants and types of the reader register map
package rfrm_pkg;

    localparam int ADDR_W = 5;
    localparam int DATA_W = 8;

    // Register offsets
    localparam logic [4:0] ADDR_CSC       = 5'h00;
    localparam logic [4:0] ADDR_PROTO     = 5'h01;
    localparam logic [4:0] ADDR_TYPEB_TX  = 5'h02;
    localparam logic [4:0] ADDR_TYPEA_HBR = 5'h03;
    localparam logic [4:0] ADDR_TX_PULSE  = 5'h06;
    localparam logic [4:0] ADDR_RX_NORESP = 5'h07;
    localparam logic [4:0] ADDR_RX_WAIT   = 5'h08;
    localparam logic [4:0] ADDR_MOD_CLK   = 5'h09;
    localparam logic [4:0] ADDR_RX_SPEC   = 5'h0A;
    localparam logic [4:0] ADDR_REG_IO    = 5'h0B;
    localparam logic [4:0] ADDR_IRQ_STAT  = 5'h0C;
    localparam logic [4:0] ADDR_COLL_MASK = 5'h0D;
    localparam logic [4:0] ADDR_COLL_POS  = 5'h0E;
    localparam logic [4:0] ADDR_SIG_LEVEL = 5'h0F;
    localparam logic [4:0] ADDR_TEST_ONE  = 5'h1A;
    localparam logic [4:0] ADDR_TEST_TWO  = 5'h1B;
    localparam logic [4:0] ADDR_FIFO_STAT = 5'h1C;
    localparam logic [4:0] ADDR_TXLEN_HI  = 5'h1D;
    localparam logic [4:0] ADDR_TXLEN_LO  = 5'h1E;
    localparam logic [4:0] ADDR_FIFO_DATA = 5'h1F;

    // Reset values
    localparam logic [7:0] CSC_RST   = 8'h01;
    localparam logic [7:0] PROTO_RST = 8'h02;
    localparam logic [7:0] OPT_RST   = 8'h00;

    // Clock output divider bits kept across a protocol preset
    localparam logic [7:0] MOD_CLKDIV_MASK = 8'h03;

    // Address/command word fields
    localparam int WORD_CMD_BIT  = 7;
    localparam int WORD_RD_BIT   = 6;
    localparam int WORD_CONT_BIT = 5;

    localparam logic [4:0] CMD_SOFT_INIT = 5'h03;

    // Wake-up time from standby
    localparam int WAKE_TIME_US = 100;
    localparam int CORE_CLK_MHZ = 250;
    localparam int WAKE_CYCLES  = WAKE_TIME_US * CORE_CLK_MHZ;

    typedef struct packed {
        logic standby;
        logic direct_mode;
        logic rf_output_enable;
        logic half_power_select;
        logic aux_input_select;
        logic reserved;
        logic receiver_force;
        logic supply_range_select;
    } rfrm_csc_t;

    typedef enum logic [3:0] {
        ST_ADDR  = 4'b0001,
        ST_WRITE = 4'b0010,
        ST_READ  = 4'b0100,
        ST_HOLD  = 4'b1000
    } rfrm_state_t;

endpackage

// File: logic/rfrm_wake_timer.sv
// Standby exit timer that flags full operation
`timescale 1ns/1ps
`default_nettype none
module rfrm_wake_timer
    import rfrm_pkg::*;
#(
    parameter int WAKE_COUNT = WAKE_CYCLES
) (
    // Clock and reset
    input  wire logic core_clk_in,
    input  wire logic rst_n_in,
    // Control
    input  wire logic standby_in,
    output logic      ready_out
);

    localparam int CNT_W = $clog2(WAKE_COUNT + 1);
    localparam logic [CNT_W-1:0] CNT_END = CNT_W'(WAKE_COUNT);

    logic [CNT_W-1:0] cnt_ff;
    logic             ready_ff;

    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cnt_ff <= '0;
        end else if (standby_in) begin
            cnt_ff <= '0;
        end else if (cnt_ff != CNT_END) begin
            cnt_ff <= cnt_ff + CNT_W'(1);
        end
    end

    // Ready only once the count has run out after leaving standby
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ready_ff <= 1'b0;
        end else begin
            ready_ff <= !standby_in && (cnt_ff == CNT_END);
        end
    end

    assign ready_out = ready_ff;

    property p_wake_rise;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        $rose(ready_out) |-> $past(cnt_ff) == CNT_END;
    endproperty
    a_wake_rise: assert property (p_wake_rise) // R2
        else $error("ready rose before wake count ran out");

    property p_standby_drops;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        standby_in |=> !ready_out;
    endproperty
    a_standby_drops: assert property (p_standby_drops) // R2
        else $error("ready high while in standby");

endmodule
`default_nettype wire

// File: bench/rfrm_host_model.sv
// Microcontroller model that drives the register bank's host port
`timescale 1ns/1ps
`default_nettype none
module rfrm_host_model (
    // Clock
    input  wire logic      core_clk_in,
    // Host port
    output var logic       frame_active_out,
    output var logic       byte_valid_out,
    output var logic [7:0] byte_out
);
    initial begin
        frame_active_out = 1'b0;
        byte_valid_out = 1'b0;
        byte_out = 8'hFF;
    end

    // Entered just after a rising edge, returns just after the next one
    task automatic put(input logic [7:0] b);
        frame_active_out = 1'b1;
        byte_valid_out = 1'b1;
        byte_out = b;
        @(posedge core_clk_in);
        #1;
    endtask

    // Released lines show the inverse so a stale byte never lingers
    task automatic stop();
        frame_active_out = 1'b0;
        byte_valid_out = 1'b0;
        byte_out = ~byte_out;
        @(posedge core_clk_in);
        #1;
    endtask
endmodule
`default_nettype wire

// File: bench/tb.sv
// Self-checking testbench of the reader register bank
`timescale 1ns/1ps
`default_nettype none
module tb;
    import rfrm_pkg::*;
    localparam int WAKE_N = 20;
    logic       clk;
    logic       rst_n;
    logic       chip_en;
    logic       frame;
    logic       bv;
    logic [7:0] hbyte;
    logic [7:0] rd_data;
    logic       rd_valid;
    logic       cmd_valid;
    logic [4:0] cmd_code;
    logic [7:0] fifo_rd_data;
    logic       fifo_rd;
    logic       fifo_wr;
    logic [7:0] fifo_wr_data;
    logic [7:0] irq_st;
    logic [7:0] coll_pos;
    logic [7:0] sig_lvl;
    logic [7:0] fifo_st;
    logic [7:0] csc_o;
    logic       active_ready;
    logic       rx_en;
    logic       tx_osc;
    logic [7:0] proto_o;
    logic [7:0] mod_o;
    int         error_cnt;
    int         checks_done;
    int         fifo_rd_cnt;

    // FIFO read strobes are counted at the edge that takes them
    always @(posedge clk) begin
        if (fifo_rd === 1'b1) begin
            fifo_rd_cnt++;
        end
    end

    rfrm_register_map #(.WAKE_COUNT(WAKE_N)) i_rfrm_register_map (
        .core_clk_in(clk), .rst_n_in(rst_n), .chip_enable_in(chip_en),
        .frame_active_in(frame), .byte_valid_in(bv), .byte_in(hbyte),
        .rd_data_out(rd_data), .rd_valid_out(rd_valid),
        .cmd_valid_out(cmd_valid), .cmd_code_out(cmd_code),
        .fifo_rd_data_in(fifo_rd_data), .fifo_rd_out(fifo_rd),
        .fifo_wr_out(fifo_wr), .fifo_wr_data_out(fifo_wr_data),
        .irq_status_in(irq_st), .collision_pos_in(coll_pos),
        .signal_level_in(sig_lvl), .fifo_status_in(fifo_st),
        .standby_out(csc_o[7]), .active_ready_out(active_ready),
        .direct_mode_out(csc_o[6]), .rf_output_enable_out(csc_o[5]),
        .receiver_enable_out(rx_en), .tx_osc_enable_out(tx_osc),
        .half_power_select_out(csc_o[4]),
        .aux_input_select_out(csc_o[3]),
        .supply_range_select_out(csc_o[0]),
        .protocol_control_out(proto_o),
        .modulator_clock_out_control_out(mod_o)
    );
    assign csc_o[2:1] = 2'b00;

    rfrm_host_model i_rfrm_host_model (
        .core_clk_in(clk), .frame_active_out(frame),
        .byte_valid_out(bv), .byte_out(hbyte)
    );

    always #2 clk = ~clk;

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        i_rfrm_host_model.put({3'b000, a});
        i_rfrm_host_model.put(d);
        i_rfrm_host_model.stop();
    endtask

    // A read slot answers one cycle after its dummy strobe
    task automatic rdc(input logic [4:0] a, input logic [7:0] exp);
        i_rfrm_host_model.put({3'b010, a});
        i_rfrm_host_model.put(8'hA5);
        chk({7'h00, rd_valid}, 8'h01);
        chk(rd_data, exp);
        i_rfrm_host_model.stop();
    endtask

    task automatic t_reset();
        rdc(ADDR_CSC, 8'h01);
        rdc(ADDR_PROTO, 8'h02);
        chk(csc_o, 8'h01);
    endtask

    task automatic t_wake();
        int n;
        wr(ADDR_CSC, 8'h81);
        chk({7'h00, csc_o[7]}, 8'h01);
        chk({7'h00, active_ready}, 8'h00);
        wr(ADDR_CSC, 8'h01);
        n = 0;
        while (active_ready !== 1'b1 && n < WAKE_N + 20) begin
            @(posedge clk);
            #1;
            n++;
        end
        chk({7'h00, n >= WAKE_N - 3 && n <= WAKE_N + 1}, 8'h01);
    endtask

    task automatic t_csc();
        logic [7:0] v;
        logic [7:0] tbl [7] = '{8'h40, 8'h20, 8'h10, 8'h08, 8'h02,
                                 8'h00, 8'h23};
        wr(ADDR_PROTO, 8'h40);
        for (int i = 0; i < 7; i++) begin
            v = tbl[i];
            wr(ADDR_CSC, v);
            chk(csc_o, {v[7:3], 3'b000} | {7'h00, v[0]});
            chk({6'h00, rx_en, tx_osc}, {8{v[1] | v[5]}} & 8'h03);
            rdc(ADDR_CSC, v);
        end
    endtask

    task automatic t_map();
        logic [4:0] rw [13] = '{5'h02, 5'h03, 5'h06, 5'h07, 5'h08, 5'h09,
            5'h0A, 5'h0B, 5'h0D, 5'h1A, 5'h1B, 5'h1D, 5'h1E};
        logic [4:0] bad [4] = '{5'h04, 5'h05, 5'h10, 5'h19};
        logic [7:0] p;
        for (int i = 0; i < 13; i++) wr(rw[i], 8'hC0 + 8'(i));
        for (int i = 0; i < 13; i++) rdc(rw[i], 8'hC0 + 8'(i));
        chk(mod_o, 8'hC5);
        wr(ADDR_COLL_POS, 8'hFF);
        wr(ADDR_SIG_LEVEL, 8'hFF);
        wr(ADDR_IRQ_STAT, 8'hFF);
        // Each source walks a pattern and its inverse so every bit moves
        for (int k = 0; k < 2; k++) begin
            p = (k == 0) ? 8'h5A : 8'hA5;
            irq_st = p;
            coll_pos = ~p;
            sig_lvl = {p[3:0], p[7:4]};
            fifo_st = p ^ 8'h0F;
            rdc(ADDR_COLL_POS, ~p);
            rdc(ADDR_SIG_LEVEL, {p[3:0], p[7:4]});
            rdc(ADDR_IRQ_STAT, p);
            rdc(ADDR_FIFO_STAT, p ^ 8'h0F);
        end
        for (int i = 0; i < 4; i++) begin
            wr(bad[i], 8'hFF);
            rdc(bad[i], 8'h00);
        end
    endtask

    task automatic t_preset();
        wr(ADDR_MOD_CLK, 8'hFF);
        wr(ADDR_TYPEB_TX, 8'h55);
        wr(ADDR_REG_IO, 8'hAA);
        wr(ADDR_PROTO, 8'h0C);
        chk(proto_o, 8'h0C);
        rdc(ADDR_MOD_CLK, 8'h03);
        rdc(ADDR_TYPEB_TX, 8'h00);
        rdc(ADDR_REG_IO, 8'h00);
    endtask

    task automatic t_cont();
        i_rfrm_host_model.put(8'h27);
        i_rfrm_host_model.put(8'h11);
        i_rfrm_host_model.put(8'h22);
        i_rfrm_host_model.stop();
        i_rfrm_host_model.put(8'h67);
        i_rfrm_host_model.put(8'h00);
        chk(rd_data, 8'h11);
        i_rfrm_host_model.put(8'h00);
        chk(rd_data, 8'h22);
        i_rfrm_host_model.stop();
        // Without the continuous bit the second data byte must be dropped
        i_rfrm_host_model.put(8'h08);
        i_rfrm_host_model.put(8'h33);
        i_rfrm_host_model.put(8'h44);
        i_rfrm_host_model.stop();
        rdc(ADDR_RX_WAIT, 8'h33);
        rdc(ADDR_MOD_CLK, 8'h03);
        i_rfrm_host_model.put(8'h3E);
        i_rfrm_host_model.put(8'h12);
        i_rfrm_host_model.put(8'h34);
        chk({7'h00, fifo_wr}, 8'h01);
        chk(fifo_wr_data, 8'h34);
        i_rfrm_host_model.put(8'h05);
        i_rfrm_host_model.stop();
        rdc(ADDR_CSC, 8'h05);
        rdc(ADDR_TXLEN_LO, 8'h12);
        fifo_rd_data = 8'h9C;
        rdc(ADDR_FIFO_DATA, 8'h9C);
        chk(8'(fifo_rd_cnt), 8'h01);
        fifo_rd_data = 8'h63;
        rdc(ADDR_FIFO_DATA, 8'h63);
        chk(8'(fifo_rd_cnt), 8'h02);
    endtask

    task automatic t_defaults();
        wr(ADDR_CSC, 8'h20);
        i_rfrm_host_model.put(8'h83);
        chk({7'h00, cmd_valid}, 8'h01);
        chk({3'b000, cmd_code}, 8'h03);
        i_rfrm_host_model.stop();
        rdc(ADDR_CSC, 8'h01);
        wr(ADDR_CSC, 8'h30);
        wr(ADDR_PROTO, 8'h0D);
        chip_en = 1'b0;
        @(posedge clk);
        #1;
        chip_en = 1'b1;
        rdc(ADDR_CSC, 8'h01);
        rdc(ADDR_PROTO, 8'h02);
        wr(ADDR_CSC, 8'h30);
        rst_n = 1'b0;
        repeat (3) @(posedge clk);
        #1;
        rst_n = 1'b1;
        repeat (4) @(posedge clk);
        #1;
        chk(csc_o, 8'h01);
        rdc(ADDR_PROTO, 8'h02);
    endtask

    initial begin
        #50000;
        error_cnt++;
        end_of_test();
    end

    initial begin
        clk = 1'b0;
        rst_n = 1'b0;
        chip_en = 1'b1;
        fifo_rd_data = 8'h00;
        irq_st = 8'h00;
        coll_pos = 8'h00;
        sig_lvl = 8'h00;
        fifo_st = 8'h00;
        error_cnt = 0;
        checks_done = 0;
        fifo_rd_cnt = 0;
        repeat (8) @(posedge clk);
        #1;
        rst_n = 1'b1;
        repeat (4) @(posedge clk);
        #1;
        t_reset();
        t_wake();
        t_csc();
        t_map();
        t_preset();
        t_cont();
        t_defaults();
        end_of_test();
    end
endmodule
`default_nettype wire
